/* File: logic/flhc_consts.svh */
// Constants for the flash lock/status host controller.
// Assumes a 250 MHz clock and an asynchronous byte-wide flash command bus.
//
// Behaviour
// - Host writes setup then confirm; device then answers reads with status.
// - Clear aborted by supply, reset or protect change must be repeated; the host repeats only reset (power-down) and protect-change aborts.
// - Host checks bit 5 after clear and clears status on error.
// - Host sends B8h then a code byte with upper six bits zero.
// - Bit 0 is reserved; host masks it when polling.
// - Host configures the pin only when ready and not suspended.
`ifndef FLHC_CONSTS_SVH
`define FLHC_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FLHC_ADDR_CTRL 8'h00
`define FLHC_ADDR_CMD 8'h04
`define FLHC_ADDR_STAT 8'h08

// Control register fields
`define FLHC_CTRL_GO 0
`define FLHC_CTRL_OP 2:1
`define FLHC_CTRL_TWO 3
`define FLHC_CTRL_AUTO 4
`define FLHC_CTRL_WP 8
`define FLHC_CTRL_PD 9

// Command register fields
`define FLHC_CMD_FIRST 7:0
`define FLHC_CMD_SECOND 15:8
`define FLHC_CMD_CLEAR 23:16
`define FLHC_CMD_CODE 25:24

// Status register fields
`define FLHC_STAT_BUSY 0
`define FLHC_STAT_DONE 1
`define FLHC_STAT_REFUSED 2
`define FLHC_STAT_UNDEF 3
`define FLHC_STAT_PULSE 4
`define FLHC_STAT_PIN 5
`define FLHC_STAT_SR 15:8
`define FLHC_STAT_RAW 23:16
`define FLHC_STAT_MODE 25:24
`define FLHC_STAT_W1C 4:1

// ----------------------------------------
// Flash status byte and pin configuration
// ----------------------------------------
`define FLHC_SR_READY 7
`define FLHC_SR_ERS_SUSP 6
`define FLHC_SR_ERASE_ERR 5
`define FLHC_SR_PROG_ERR 4
`define FLHC_SR_PROG_SUSP 2
`define FLHC_SR_RSVD 0
`define FLHC_PIN_CFG_CMD 8'hb8
`define FLHC_PIN_LEVEL 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define FLHC_CLK_NS 4
`define FLHC_WE_NS 60
`define FLHC_RD_NS 100
`define FLHC_GAP_NS 40
`define FLHC_PULSE_NS 250
`define FLHC_WE_CYC ((`FLHC_WE_NS + `FLHC_CLK_NS - 1) / `FLHC_CLK_NS)
`define FLHC_RD_CYC ((`FLHC_RD_NS + `FLHC_CLK_NS - 1) / `FLHC_CLK_NS)
`define FLHC_GAP_CYC ((`FLHC_GAP_NS + `FLHC_CLK_NS - 1) / `FLHC_CLK_NS)
`define FLHC_PULSE_MAX_CYC ((2 * `FLHC_PULSE_NS) / `FLHC_CLK_NS)
`define FLHC_SYNC_LAT 3
`define FLHC_CNT_MAX 250

`endif

/* File: logic/flhc_pkg.sv */
// Types shared by the flash lock/status host controller.
// Assumes the constants header is on the include path.
package flhc_pkg;

  typedef logic [7:0] flhc_byte_t;

  typedef struct packed {
    logic chip_select_n;
    logic write_n;
    logic read_n;
    logic reset_powerdown_n;
    logic write_protect;
    logic dq_oe_n;
    flhc_byte_t dq;
  } flhc_pins_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WRITE = 5'h02,
    ST_GAP = 5'h04,
    ST_READ = 5'h08,
    ST_DECIDE = 5'h10
  } flhc_state_e;

  typedef enum logic [1:0] {
    OP_CLR_LOCKS = 2'h0,
    OP_PIN_CFG = 2'h1,
    OP_RAW = 2'h2
  } flhc_op_e;

  typedef enum logic [1:0] {
    ACT_WRITE = 2'h0,
    ACT_READ = 2'h1,
    ACT_DONE = 2'h2,
    ACT_REFUSE = 2'h3
  } flhc_act_e;

endpackage

/* File: logic/flhc_sync.sv */
// Two-stage synchroniser for inputs arriving from the flash pins.
// Assumes the inputs are quasi-static across a bus read window.
`timescale 1ns/10ps
module flhc_sync #(
  parameter int WIDTH = 1
) (
  input logic clk,
  input logic reset,
  input logic ce,
  input logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

/* File: logic/flhc_ctrl.sv */
// Host controller driving a flash device command bus and status pin.
// Assumes a Wishbone classic master and a byte-wide asynchronous flash.
`timescale 1ns/10ps
`include "flhc_consts.svh"
module flhc_ctrl
  import flhc_pkg::*;
#(
  parameter int WE_CYC = `FLHC_WE_CYC,
  parameter int RD_CYC = `FLHC_RD_CYC,
  parameter int GAP_CYC = `FLHC_GAP_CYC
) (
  input logic clk,
  input logic reset,
  input logic ce,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output flhc_pins_s flash_o,
  input logic [7:0] flash_dq_i,
  input logic status_pin
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (WE_CYC < 1 || WE_CYC > `FLHC_CNT_MAX || RD_CYC < 1 || RD_CYC > `FLHC_CNT_MAX ||
      GAP_CYC < 1 || GAP_CYC > `FLHC_CNT_MAX) begin : g_bad_timing
    $error("flhc_ctrl timing counts out of range");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  flhc_state_e state_r;
  flhc_op_e op_r, ctrl_op_r;
  flhc_act_e act;
  flhc_byte_t act_byte, byte_r, cmd_first_r, cmd_second_r, cmd_clear_r, last_sr_r, last_rd_r, dq_sync;
  logic [2:0] step_r, act_step, wr_cnt_r;
  logic [7:0] cnt_r, low_cnt_r;
  logic [1:0] cmd_code_r, pin_mode_r;
  logic ctrl_two_r, ctrl_auto_r, ctrl_wp_r, ctrl_pd_r, wp_start_r, go_pend_r, repeat_r;
  logic done_r, refused_r, undef_r, pulse_r, was_write_r, pin_d_r, pin_sync;
  logic acc, wr, wr_ctrl, wr_cmd, wr_stat, start, abort, busy, rd_end, pulse_evt;
  logic [31:0] rd_mux;

  flhc_sync #(.WIDTH(9)) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d({status_pin, flash_dq_i}),
    .q({pin_sync, dq_sync})
  );

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i;
  assign wr_ctrl = wr & (wb_adr_i == `FLHC_ADDR_CTRL);
  assign wr_cmd = wr & (wb_adr_i == `FLHC_ADDR_CMD);
  assign wr_stat = wr & (wb_adr_i == `FLHC_ADDR_STAT) & wb_sel_i[0];

  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      `FLHC_ADDR_CTRL: begin
        rd_mux[`FLHC_CTRL_OP] = ctrl_op_r;
        rd_mux[`FLHC_CTRL_TWO] = ctrl_two_r;
        rd_mux[`FLHC_CTRL_AUTO] = ctrl_auto_r;
        rd_mux[`FLHC_CTRL_WP] = ctrl_wp_r;
        rd_mux[`FLHC_CTRL_PD] = ctrl_pd_r;
      end
      `FLHC_ADDR_CMD: begin
        rd_mux[`FLHC_CMD_FIRST] = cmd_first_r;
        rd_mux[`FLHC_CMD_SECOND] = cmd_second_r;
        rd_mux[`FLHC_CMD_CLEAR] = cmd_clear_r;
        rd_mux[`FLHC_CMD_CODE] = cmd_code_r;
      end
      `FLHC_ADDR_STAT: begin
        rd_mux[`FLHC_STAT_BUSY] = busy;
        rd_mux[`FLHC_STAT_DONE] = done_r;
        rd_mux[`FLHC_STAT_REFUSED] = refused_r;
        rd_mux[`FLHC_STAT_UNDEF] = undef_r;
        rd_mux[`FLHC_STAT_PULSE] = pulse_r;
        rd_mux[`FLHC_STAT_PIN] = pin_sync;
        rd_mux[`FLHC_STAT_SR] = last_sr_r;
        rd_mux[`FLHC_STAT_RAW] = last_rd_r;
        rd_mux[`FLHC_STAT_MODE] = pin_mode_r;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce) begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Control and command registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_op_r <= OP_RAW;
      ctrl_two_r <= 1'b0;
      ctrl_auto_r <= 1'b0;
      ctrl_wp_r <= 1'b0;
      ctrl_pd_r <= 1'b0;
      go_pend_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl && wb_sel_i[0]) begin
        ctrl_op_r <= flhc_op_e'(wb_dat_i[`FLHC_CTRL_OP]);
        ctrl_two_r <= wb_dat_i[`FLHC_CTRL_TWO];
        ctrl_auto_r <= wb_dat_i[`FLHC_CTRL_AUTO];
      end
      if (wr_ctrl && wb_sel_i[1]) begin
        ctrl_wp_r <= wb_dat_i[`FLHC_CTRL_WP];
        ctrl_pd_r <= wb_dat_i[`FLHC_CTRL_PD];
      end
      // A go seen while busy waits for idle
      if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`FLHC_CTRL_GO]) begin
        go_pend_r <= 1'b1;
      end else if (start && !repeat_r) begin
        go_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_first_r <= '0;
      cmd_second_r <= '0;
      cmd_clear_r <= '0;
      cmd_code_r <= `FLHC_PIN_LEVEL;
    end else if (ce && wr_cmd) begin
      if (wb_sel_i[0]) cmd_first_r <= wb_dat_i[`FLHC_CMD_FIRST];
      if (wb_sel_i[1]) cmd_second_r <= wb_dat_i[`FLHC_CMD_SECOND];
      if (wb_sel_i[2]) cmd_clear_r <= wb_dat_i[`FLHC_CMD_CLEAR];
      if (wb_sel_i[3]) cmd_code_r <= wb_dat_i[`FLHC_CMD_CODE];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign busy = (state_r != ST_IDLE);
  // A repeat of an aborted clear outranks a new go
  assign start = (state_r == ST_IDLE) && !ctrl_pd_r && (repeat_r || go_pend_r);
  assign abort = busy && (ctrl_pd_r || (op_r == OP_CLR_LOCKS && ctrl_wp_r != wp_start_r));
  assign rd_end = (state_r == ST_READ) && (cnt_r == 8'(RD_CYC + `FLHC_SYNC_LAT - 1));

  always_comb begin
    act = ACT_DONE;
    act_byte = cmd_first_r;
    act_step = step_r;
    unique case (op_r)
      OP_CLR_LOCKS: begin
        unique case (step_r)
          3'h0: act = ACT_WRITE;
          3'h1: begin
            act = ACT_WRITE;
            act_byte = cmd_second_r;
          end
          3'h2: act = ACT_READ;
          3'h3: begin
            if (!last_sr_r[`FLHC_SR_READY]) begin
              act = ACT_READ;
              act_step = 3'h2;
            end else if (last_sr_r[`FLHC_SR_ERASE_ERR] && ctrl_auto_r) begin
              act = ACT_WRITE;
              act_byte = cmd_clear_r;
            end
          end
          default: act = ACT_DONE;
        endcase
      end
      OP_PIN_CFG: begin
        unique case (step_r)
          3'h0: act = ACT_READ;
          3'h1: begin
            // Suspended or busy devices reject configuration
            if (!last_sr_r[`FLHC_SR_READY] || last_sr_r[`FLHC_SR_ERS_SUSP] || last_sr_r[`FLHC_SR_PROG_SUSP]) begin
              act = ACT_REFUSE;
            end else begin
              act = ACT_WRITE;
              act_byte = `FLHC_PIN_CFG_CMD;
            end
          end
          3'h2: begin
            act = ACT_WRITE;
            act_byte = {6'h00, cmd_code_r};
          end
          3'h3: act = ACT_READ;
          3'h4: begin
            if (!last_sr_r[`FLHC_SR_READY]) begin
              act = ACT_READ;
              act_step = 3'h3;
            end
          end
          default: act = ACT_DONE;
        endcase
      end
      OP_RAW: begin
        unique case (step_r)
          3'h0: act = ACT_WRITE;
          3'h1: begin
            if (ctrl_two_r) begin
              act = ACT_WRITE;
              act_byte = cmd_second_r;
            end else begin
              act = ACT_READ;
              act_step = 3'h2;
            end
          end
          3'h2: act = ACT_READ;
          default: act = ACT_DONE;
        endcase
      end
      default: act = ACT_DONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      op_r <= OP_RAW;
      step_r <= '0;
      cnt_r <= '0;
      byte_r <= '0;
      wp_start_r <= 1'b0;
    end else if (ce) begin
      if (abort) begin
        state_r <= ST_IDLE;
        cnt_r <= '0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            if (start) begin
              op_r <= repeat_r ? OP_CLR_LOCKS : ctrl_op_r;
              wp_start_r <= ctrl_wp_r;
              step_r <= '0;
              state_r <= ST_DECIDE;
            end
          end
          ST_WRITE: begin
            if (cnt_r == 8'(WE_CYC - 1)) begin
              cnt_r <= '0;
              state_r <= ST_GAP;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
          ST_READ: begin
            if (rd_end) begin
              cnt_r <= '0;
              state_r <= ST_GAP;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
          ST_GAP: begin
            if (cnt_r == 8'(GAP_CYC - 1)) begin
              cnt_r <= '0;
              step_r <= step_r + 3'h1;
              state_r <= ST_DECIDE;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
          ST_DECIDE: begin
            step_r <= act_step;
            byte_r <= act_byte;
            unique case (act)
              ACT_WRITE: state_r <= ST_WRITE;
              ACT_READ: state_r <= ST_READ;
              ACT_DONE, ACT_REFUSE: state_r <= ST_IDLE;
            endcase
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Flash pins
  // ----------------------------------------
  // Data is held one gap past the write strobe for hold time
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_o <= '{chip_select_n: 1'b1, write_n: 1'b1, read_n: 1'b1, reset_powerdown_n: 1'b0,
                   write_protect: 1'b0, dq_oe_n: 1'b1, dq: 8'h00};
      was_write_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_WRITE) was_write_r <= 1'b1;
      else if (state_r != ST_GAP) was_write_r <= 1'b0;
      flash_o.chip_select_n <= !(state_r == ST_WRITE || state_r == ST_READ);
      flash_o.write_n <= (state_r != ST_WRITE);
      flash_o.read_n <= (state_r != ST_READ);
      flash_o.reset_powerdown_n <= !ctrl_pd_r;
      flash_o.write_protect <= ctrl_wp_r;
      flash_o.dq_oe_n <= !(state_r == ST_WRITE || (state_r == ST_GAP && was_write_r));
      flash_o.dq <= byte_r;
    end
  end

  // ----------------------------------------
  // Read capture and status flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      last_rd_r <= '0;
      last_sr_r <= '0;
    end else if (ce && rd_end && !abort) begin
      last_rd_r <= dq_sync;
      if (op_r != OP_RAW) begin
        last_sr_r <= dq_sync & ~(8'h01 << `FLHC_SR_RSVD);
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
      undef_r <= 1'b0;
      pulse_r <= 1'b0;
      repeat_r <= 1'b0;
    end else if (ce) begin
      done_r <= (state_r == ST_DECIDE && act == ACT_DONE && !abort) ||
                (done_r && !(wr_stat && wb_dat_i[`FLHC_STAT_DONE]));
      refused_r <= (state_r == ST_DECIDE && act == ACT_REFUSE && !abort) ||
                   (refused_r && !(wr_stat && wb_dat_i[`FLHC_STAT_REFUSED]));
      undef_r <= (abort && op_r == OP_CLR_LOCKS) || (undef_r && !(wr_stat && wb_dat_i[`FLHC_STAT_UNDEF]));
      pulse_r <= pulse_evt || (pulse_r && !(wr_stat && wb_dat_i[`FLHC_STAT_PULSE]));
      if (abort && op_r == OP_CLR_LOCKS) repeat_r <= 1'b1;
      else if (start) repeat_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Status pin mode and pulse detection
  // ----------------------------------------
  // Long lows in pulse mode are taken as busy levels, not completions
  assign pulse_evt = pin_sync && !pin_d_r && (pin_mode_r != `FLHC_PIN_LEVEL) &&
                     (low_cnt_r <= 8'(`FLHC_PULSE_MAX_CYC));

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_d_r <= 1'b1;
      low_cnt_r <= '0;
      pin_mode_r <= `FLHC_PIN_LEVEL;
    end else if (ce) begin
      pin_d_r <= pin_sync;
      if (pin_sync) low_cnt_r <= '0;
      else if (low_cnt_r != 8'hff) low_cnt_r <= low_cnt_r + 8'h01;
      if (ctrl_pd_r) begin
        pin_mode_r <= `FLHC_PIN_LEVEL;
      end else if (state_r == ST_DECIDE && op_r == OP_PIN_CFG && step_r == 3'h4 && act == ACT_DONE &&
                   !(last_sr_r[`FLHC_SR_ERASE_ERR] && last_sr_r[`FLHC_SR_PROG_ERR])) begin
        pin_mode_r <= cmd_code_r;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_cnt_r <= '0;
    end else if (ce) begin
      if (start) wr_cnt_r <= '0;
      else if (flash_o.write_n && state_r == ST_WRITE && cnt_r == 8'h00) wr_cnt_r <= wr_cnt_r + 3'h1;
    end
  end

  sequence s_cfg_prefix;
    state_r == ST_WRITE && op_r == OP_PIN_CFG && step_r == 3'h1;
  endsequence
  sequence s_cfg_code;
    state_r == ST_WRITE && op_r == OP_PIN_CFG && step_r == 3'h2;
  endsequence
  sequence s_clr_err_done;
    ce && state_r == ST_DECIDE && op_r == OP_CLR_LOCKS && step_r == 3'h3 && !abort &&
    last_sr_r[`FLHC_SR_READY] && last_sr_r[`FLHC_SR_ERASE_ERR] && ctrl_auto_r;
  endsequence

  a_cfg_prefix: assert property (@(posedge clk) disable iff (reset) s_cfg_prefix |-> byte_r == `FLHC_PIN_CFG_CMD)
    else $error("pin config prefix byte wrong");
  a_cfg_code: assert property (@(posedge clk) disable iff (reset) s_cfg_code |-> byte_r[7:2] == 6'h00)
    else $error("pin config code has upper bits set");
  a_cfg_ready: assert property (@(posedge clk) disable iff (reset)
    ($fell(flash_o.write_n) && op_r == OP_PIN_CFG) |->
    last_sr_r[`FLHC_SR_READY] && !last_sr_r[`FLHC_SR_ERS_SUSP] && !last_sr_r[`FLHC_SR_PROG_SUSP])
    else $error("pin configured while busy or suspended");
  a_two_writes: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_READ && op_r == OP_CLR_LOCKS) |-> wr_cnt_r == 3'h2)
    else $error("clear sequence not two writes before status read");
  a_sr0_masked: assert property (@(posedge clk) disable iff (reset) !last_sr_r[`FLHC_SR_RSVD])
    else $error("reserved status bit not masked");
  a_auto_clear: assert property (@(posedge clk) disable iff (reset)
    s_clr_err_done |=> (state_r == ST_WRITE && byte_r == cmd_clear_r) ##2 !flash_o.write_n)
    else $error("clear-status not issued after clear error");
  a_abort_flag: assert property (@(posedge clk) disable iff (reset)
    (ce && abort && op_r == OP_CLR_LOCKS) |=> undef_r && repeat_r && state_r == ST_IDLE)
    else $error("aborted clear not flagged for repeat");
  a_repeat_start: assert property (@(posedge clk) disable iff (reset)
    (ce && start && repeat_r) |=> op_r == OP_CLR_LOCKS && state_r == ST_DECIDE && !repeat_r)
    else $error("aborted clear not repeated");
  a_pulse_seen: assert property (@(posedge clk) disable iff (reset) (ce && pulse_evt) |=> pulse_r)
    else $error("status pin pulse missed");
  a_ack_pulse: assert property (@(posedge clk) disable iff (reset) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_bus_excl: assert property (@(posedge clk) disable iff (reset) !(!flash_o.write_n && !flash_o.read_n))
    else $error("write and read strobes both low");

endmodule

/* File: test/flhc_flash_model.sv */
// Behavioural flash device seen through the controller's pin struct.
// Assumes pins change only on clk edges; command codes are arbitrary.
`timescale 1ns/10ps
module flhc_flash_model
  import flhc_pkg::*;
#(
  parameter logic [7:0] CLR_SETUP = 8'h60,
  parameter logic [7:0] CONFIRM = 8'hd0,
  parameter logic [7:0] CLR_STAT = 8'h50,
  parameter logic [7:0] ERASE = 8'h20,
  parameter int BUSY_CYC = 20,
  parameter int PULSE_CYC = 62
) (
  input wire logic clk,
  input wire flhc_pins_s pins,
  input wire logic supply_low,
  output logic [7:0] dq,
  output logic sts_low,
  output logic [7:0] locks,
  output logic [7:0] sr
);
  // ----
  // Command decode
  // ----
  logic [7:0] wbyte;
  logic [1:0] cfg = 2'h0;
  logic wact = 1'b0, clr_p = 1'b0, cfg_p = 1'b0, ers_p = 1'b0, ers = 1'b0;
  int busy = 0;
  int pulse = 0;
  initial locks = 8'hff;
  initial sr = 8'h00;
  // Idle bus shows the inverse, so stale status never passes
  assign dq = (!pins.read_n && !pins.chip_select_n) ? {busy == 0, sr[6:1], 1'b0} : ~{busy == 0, sr[6:0]};
  // Suspend bits stay low: this model never suspends
  assign sts_low = (cfg == 2'h0 && busy != 0) || pulse != 0;
  task automatic take(input logic [7:0] b);
    if (clr_p) begin
      clr_p = 1'b0;
      if (b != CONFIRM) sr[5:4] = 2'h3;
      else if (!pins.write_protect) sr = sr | 8'h22;
      else if (supply_low) sr = sr | 8'h28;
      else begin
        locks = 8'h00;
        busy = BUSY_CYC;
        ers = 1'b0;
      end
    end else if (cfg_p) begin
      cfg_p = 1'b0;
      if (b[7:2] != 6'h0) sr[5:4] = 2'h3;
      else cfg = b[1:0];
    end else if (ers_p) begin
      ers_p = 1'b0;
      // Locked block erases only with write-protect high
      if (locks[0] && !pins.write_protect) sr = sr | 8'h22;
      else begin
        busy = BUSY_CYC;
        ers = 1'b1;
      end
    end else if (b == CLR_SETUP) clr_p = 1'b1;
    else if (b == 8'hb8) cfg_p = 1'b1;
    else if (b == ERASE) ers_p = 1'b1;
    else if (b == CLR_STAT) sr = 8'h00;
  endtask
  always @(posedge clk) begin
    if (!pins.reset_powerdown_n) begin
      cfg = 2'h0;
      busy = 0;
      pulse = 0;
      {wact, clr_p, cfg_p, ers_p} = 4'h0;
    end else begin
      if (busy == 1 && ers && cfg[0]) pulse = PULSE_CYC;
      if (busy != 0) busy = busy - 1;
      if (pulse != 0) pulse = pulse - 1;
      if (!pins.write_n && !pins.chip_select_n && !pins.dq_oe_n) begin
        wbyte = pins.dq;
        wact = 1'b1;
      end else if (wact) begin
        wact = 1'b0;
        take(wbyte);
      end
    end
  end
endmodule

/* File: test/flhc_ctrl_tb.sv */
// Self-checking bench for the flash lock/status host controller.
// Assumes the behavioural flash model stands on the pin side.
`timescale 1ns/10ps
module flhc_ctrl_tb;
  import flhc_pkg::*;
  localparam logic [31:0] WP = 32'h110;
  localparam logic [31:0] PD = 32'h200;
  logic clk, reset, cyc, stb, we, ack, supply_low, sts_low;
  logic [7:0] adr, mdq, locks, sr;
  logic [31:0] dat, rdat, st;
  flhc_pins_s pins;
  int mismatches = 0;
  int cmp_count = 0;
  // Open-drain status line with pull-up
  flhc_ctrl #(.WE_CYC(2), .RD_CYC(2), .GAP_CYC(1)) flhc_ctrl_i (.clk(clk), .reset(reset), .ce(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .flash_o(pins), .flash_dq_i(mdq), .status_pin(!sts_low));
  flhc_flash_model flhc_flash_model_i (.clk(clk), .pins(pins), .supply_low(supply_low), .dq(mdq),
    .sts_low(sts_low), .locks(locks), .sr(sr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----
  // Bus and check tasks
  // ----
  task automatic give_verdict();
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    st = rdat;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic start(input logic [31:0] c);
    bus(1'b1, 8'h08, 32'h1e);
    bus(1'b1, 8'h00, c | 32'h1);
  endtask
  // Polls STAT until bit b sets; a missing bit ends the run only when must is set
  task automatic poll(input int b, input int lim, input logic must);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h08, 32'h0);
      n++;
    end while (st[b] !== 1'b1 && n < lim);
    if (must && st[b] !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    {cyc, stb, we, supply_low, reset} = 5'h01;
    adr = 8'h00;
    dat = 32'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Let the status pin pass the synchroniser before its level is checked
    repeat (4) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    chk(st, 32'h20);
    bus(1'b0, 8'h0c, 32'h0);
    chk(st, 32'h0);
    bus(1'b1, 8'h04, 32'h50d060);
    start(32'h10);
    poll(1, 200, 1'b1);
    chk({st[15:8], locks, sr}, 32'ha2ff00);
    supply_low <= 1'b1;
    start(WP);
    poll(1, 200, 1'b1);
    chk({st[15:8], locks, sr}, 32'ha8ff00);
    supply_low <= 1'b0;
    start(WP);
    bus(1'b1, 8'h00, WP | PD);
    bus(1'b1, 8'h00, WP);
    poll(1, 400, 1'b1);
    chk({st[15:8], 4'h0, st[3:0], locks}, 32'h800a00);
    bus(1'b1, 8'h04, 32'h500060);
    start(WP);
    poll(1, 200, 1'b1);
    chk({st[15:8], sr}, 32'hb000);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h04, {6'h0, 2'(m), 8'h0, 16'hd020});
      start(WP | 32'h2);
      poll(1, 200, 1'b1);
      chk(32'(st[25:24]), 32'(m));
      start(WP | 32'hc);
      poll(1, 200, 1'b1);
      chk(32'(st[23:16]), 32'h0);
      poll(4, 60, 1'b0);
      chk(32'(st[4]), 32'(m % 2));
    end
    bus(1'b1, 8'h04, 32'h04b8);
    start(WP | 32'hc);
    poll(1, 200, 1'b1);
    chk({st[25:24], st[23:16]}, 32'h3b0);
    bus(1'b1, 8'h00, WP | PD);
    bus(1'b0, 8'h08, 32'h0);
    chk(32'(st[25:24]), 32'h0);
    bus(1'b1, 8'h00, WP);
    give_verdict();
  end
endmodule
